// [verilog/aoc_pkg.sv]
package aoc_pkg;

	// Timing
	localparam int CLK_NS      = 8;
	localparam int TICK_NS     = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int MS_W        = 12;
	localparam int HOLD_W      = 18;
	localparam int CNT_W       = 16;
	localparam logic [MS_W-1:0] DELAY_MAX_MS = 12'hbb8;
	localparam logic [MS_W-1:0] WIDTH_MIN_MS = 12'h3e8;
	localparam logic [MS_W-1:0] WIDTH_MAX_MS = 12'hbb8;
	localparam logic [MS_W-1:0] WIDTH_RST_MS = 12'h3e8;
	localparam logic [HOLD_W-1:0] MS_PER_S   = 18'h003e8;

	// Register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DELAY  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_HOLD   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_LOW_W  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_HIGH_W = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CNT1   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CNT2   = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_CLEAR  = 8'h20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ACT_HIGH  = 2'b00,
		ACT_LOW   = 2'b01,
		ACT_PULSE = 2'b10
	} aoc_act_type;

	typedef enum logic [1:0] {
		INIT_LAST = 2'b00,
		INIT_HIGH = 2'b01,
		INIT_LOW  = 2'b10
	} aoc_init_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN   = 2'b10
	} aoc_state_type;

	// Control word, bit 0 upward: en, on_act, off_act, init, src, inv
	typedef struct packed {
		logic [1:0]   inv;
		logic         src;
		aoc_init_type init;
		aoc_act_type  off_act;
		aoc_act_type  on_act;
		logic         en;
	} aoc_cfg_type;

	localparam int CTRL_W = 10;
	localparam aoc_cfg_type CFG_RST = '{inv: 2'b00, src: 1'b0, init: INIT_LOW,
		off_act: ACT_LOW, on_act: ACT_HIGH, en: 1'b0};

endpackage

// [verilog/aoc_ms_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module aoc_ms_tick #(
	parameter int TICK_CYCLES = aoc_pkg::TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output var  logic tick
);
	localparam int W = $clog2(TICK_CYCLES);
	localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

	logic [W-1:0] cnt_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_tick_lone;
		tick |=> !tick;
	endproperty
	a_tick_lone: assert property (p_tick_lone) else $error("tick lasted two cycles");

endmodule
`default_nettype wire

// [verilog/aoc_alarm_cond.sv]
`timescale 1ns/1ps
`default_nettype none
module aoc_alarm_cond (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    pin,
	input  wire logic                    inv,
	input  wire logic                    clr,
	output var  logic                    alarm,
	output var  logic                    edge_seen,
	output var  logic [aoc_pkg::CNT_W-1:0] count
);
	logic alarm_d;
	logic rise_d;

	assign alarm_d = pin ^ inv;
	assign rise_d  = alarm_d & ~alarm;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			alarm     <= 1'b0;
			edge_seen <= 1'b0;
		end
		else
		begin
			alarm     <= alarm_d;
			edge_seen <= alarm_d ^ alarm;
		end
	end

	// Clear and a new event together keep the event
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			count <= '0;
		else if (clr)
			count <= rise_d ? aoc_pkg::CNT_W'(1) : '0;
		else if (rise_d)
			count <= count + aoc_pkg::CNT_W'(1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_clr;
		clr && !rise_d |=> count == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("counter not cleared");

	property p_polarity;
		##1 alarm == ($past(pin) ^ $past(inv));
	endproperty
	a_polarity: assert property (p_polarity) else $error("alarm polarity wrong");

endmodule
`default_nettype wire

// [verilog/aoc_output_ctrl.sv]
// Notes on behaviour
// - Channel has an enable, off by default; disabled means no alarm actions.
// - Alarm assertion runs the assert action: high, low or pulse; default high.
// - Alarm removal runs the release action: high, low or pulse; default low.
// - Pulse action is a repeating square wave of programmed low and high widths.
// - At power-up output takes initial state: last, high or low; default low.
// - Level at power-off is retained and restored when power returns.
// - Start-up delay 0 to 3000 ms before each assert or release action; zero means immediate.
// - Action stops after hold time 0 to 255 s; zero keeps it until next.
// - Pulse low width 1000 to 3000 ms, default 1000, used only for pulses.
// - Pulse high width 1000 to 3000 ms, default 1000, used only for pulses.
// - Trigger source is first or second input alarm, default first.
// - Output and input status readable; clear resets either input's alarm counter.
// - Input alarm active on high input; inversion swaps that relation.
`timescale 1ns/1ps
`default_nettype none
module aoc_output_ctrl #(
	parameter int TICK_CYCLES = aoc_pkg::TICK_CYCLES
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [aoc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output var  logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output var  logic                       s_axi_wready,
	output var  logic [1:0]                 s_axi_bresp,
	output var  logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [aoc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output var  logic                       s_axi_arready,
	output var  logic [31:0]                s_axi_rdata,
	output var  logic [1:0]                 s_axi_rresp,
	output var  logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [1:0]                 sensed_input_channel,
	input  wire logic                       saved_level,
	output var  logic                       out_level
);
	localparam int MW = aoc_pkg::MS_W;
	localparam int HW = aoc_pkg::HOLD_W;

	aoc_pkg::aoc_cfg_type   cfg_q;
	aoc_pkg::aoc_state_type st_q;
	aoc_pkg::aoc_act_type   act_q;
	aoc_pkg::aoc_act_type   act_new;
	logic [MW-1:0]          delay_q;
	logic [7:0]             hold_q;
	logic [MW-1:0]          low_w_q;
	logic [MW-1:0]          high_w_q;
	logic [MW-1:0]          ms_q;
	logic [MW-1:0]          ms_nx;
	logic [HW-1:0]          hold_ms_q;
	logic [HW-1:0]          hold_lim;
	logic [1:0]             clr_q;
	logic                   init_pend_q;
	logic [aoc_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   do_wr;
	logic                   tick;
	logic [1:0]             alarm;
	logic [1:0]             edge_seen;
	logic [aoc_pkg::CNT_W-1:0] cnt [2];
	logic                   trig;
	logic                   sel_alarm;
	logic                   go_run;
	logic                   phase_end;
	logic                   hold_end;
	logic                   init_apply;
	logic [31:0]            wr_val;
	logic [31:0]            rd_val;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic [MW-1:0] clamp_w(input logic [MW-1:0] v);
		if (v < aoc_pkg::WIDTH_MIN_MS)
			return aoc_pkg::WIDTH_MIN_MS;
		if (v > aoc_pkg::WIDTH_MAX_MS)
			return aoc_pkg::WIDTH_MAX_MS;
		return v;
	endfunction

	aoc_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk  (clk),
		.rst_n(rst_n),
		.tick (tick)
	);

	for (genvar g = 0; g < 2; g++)
	begin : g_in
		aoc_alarm_cond u_cond (
			.clk      (clk),
			.rst_n    (rst_n),
			.pin      (sensed_input_channel[g]),
			.inv      (cfg_q.inv[g]),
			.clr      (clr_q[g]),
			.alarm    (alarm[g]),
			.edge_seen(edge_seen[g]),
			.count    (cnt[g])
		);
	end

	// Write channel: address and data taken in either order
	assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= aoc_pkg::RESP_OKAY;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q > aoc_pkg::OFF_CLEAR || awaddr_q[1:0] != 2'h0) ?
					aoc_pkg::RESP_SLVERR : aoc_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb
	begin
		case (awaddr_q)
			aoc_pkg::OFF_CTRL:   wr_val = merge(32'(cfg_q), wdata_q, wstrb_q);
			aoc_pkg::OFF_DELAY:  wr_val = merge(32'(delay_q), wdata_q, wstrb_q);
			aoc_pkg::OFF_HOLD:   wr_val = merge(32'(hold_q), wdata_q, wstrb_q);
			aoc_pkg::OFF_LOW_W:  wr_val = merge(32'(low_w_q), wdata_q, wstrb_q);
			aoc_pkg::OFF_HIGH_W: wr_val = merge(32'(high_w_q), wdata_q, wstrb_q);
			default:             wr_val = merge(32'h0, wdata_q, wstrb_q);
		endcase
	end

	// Out-of-range delay and widths are clamped, never rejected; hold keeps only its low 8 bits
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_q    <= aoc_pkg::CFG_RST;
			delay_q  <= '0;
			hold_q   <= '0;
			low_w_q  <= aoc_pkg::WIDTH_RST_MS;
			high_w_q <= aoc_pkg::WIDTH_RST_MS;
			clr_q    <= '0;
		end
		else
		begin
			clr_q <= '0;
			if (do_wr)
			begin
				case (awaddr_q)
					aoc_pkg::OFF_CTRL:   cfg_q    <= aoc_pkg::aoc_cfg_type'(wr_val[aoc_pkg::CTRL_W-1:0]);
					aoc_pkg::OFF_DELAY:  delay_q  <= (wr_val[15:0] > 16'(aoc_pkg::DELAY_MAX_MS)) ?
						aoc_pkg::DELAY_MAX_MS : wr_val[MW-1:0];
					aoc_pkg::OFF_HOLD:   hold_q   <= wr_val[7:0];
					aoc_pkg::OFF_LOW_W:  low_w_q  <= (wr_val[15:MW] != '0) ? aoc_pkg::WIDTH_MAX_MS :
						clamp_w(wr_val[MW-1:0]);
					aoc_pkg::OFF_HIGH_W: high_w_q <= (wr_val[15:MW] != '0) ? aoc_pkg::WIDTH_MAX_MS :
						clamp_w(wr_val[MW-1:0]);
					aoc_pkg::OFF_CLEAR:  clr_q    <= wr_val[1:0];
					default:             clr_q    <= '0;
				endcase
			end
		end
	end

	// Read channel
	always_comb
	begin
		case (s_axi_araddr)
			aoc_pkg::OFF_CTRL:   rd_val = 32'(cfg_q);
			aoc_pkg::OFF_DELAY:  rd_val = 32'(delay_q);
			aoc_pkg::OFF_HOLD:   rd_val = 32'(hold_q);
			aoc_pkg::OFF_LOW_W:  rd_val = 32'(low_w_q);
			aoc_pkg::OFF_HIGH_W: rd_val = 32'(high_w_q);
			aoc_pkg::OFF_STATUS: rd_val = {26'h0, init_pend_q, st_q, alarm, out_level};
			aoc_pkg::OFF_CNT1:   rd_val = 32'(cnt[0]);
			aoc_pkg::OFF_CNT2:   rd_val = 32'(cnt[1]);
			default:             rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= aoc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= (s_axi_araddr > aoc_pkg::OFF_CLEAR || s_axi_araddr[1:0] != 2'h0) ?
				aoc_pkg::RESP_SLVERR : aoc_pkg::RESP_OKAY;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Sequencing decisions
	assign trig      = cfg_q.en && edge_seen[cfg_q.src];
	assign sel_alarm = alarm[cfg_q.src];
	assign act_new   = sel_alarm ? cfg_q.on_act : cfg_q.off_act;
	assign ms_nx     = ms_q + MW'(1);
	assign hold_lim  = HW'(hold_q) * aoc_pkg::MS_PER_S;

	always_comb
	begin
		go_run     = cfg_q.en && ((trig && delay_q == '0) ||
			(!trig && st_q == aoc_pkg::ST_DELAY && tick && ms_nx >= delay_q));
		// Shortened hold while running stops at once, not after a wrap
		hold_end   = cfg_q.en && !trig && st_q == aoc_pkg::ST_RUN && hold_q != '0 &&
			(hold_ms_q >= hold_lim || (tick && hold_ms_q + HW'(1) >= hold_lim));
		phase_end  = cfg_q.en && !trig && !hold_end && st_q == aoc_pkg::ST_RUN &&
			act_q == aoc_pkg::ACT_PULSE && tick && ms_nx >= (out_level ? high_w_q : low_w_q);
		init_apply = init_pend_q && do_wr && awaddr_q == aoc_pkg::OFF_CTRL;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q      <= aoc_pkg::ST_IDLE;
			act_q     <= aoc_pkg::ACT_HIGH;
			ms_q      <= '0;
			hold_ms_q <= '0;
		end
		else if (!cfg_q.en)
			st_q <= aoc_pkg::ST_IDLE;
		else if (trig)
		begin
			act_q     <= act_new;
			ms_q      <= '0;
			hold_ms_q <= '0;
			st_q      <= go_run ? aoc_pkg::ST_RUN : aoc_pkg::ST_DELAY;
		end
		else
		begin
			case (st_q)
				aoc_pkg::ST_DELAY:
					if (tick)
					begin
						ms_q <= go_run ? '0 : ms_nx;
						st_q <= go_run ? aoc_pkg::ST_RUN : aoc_pkg::ST_DELAY;
					end
				aoc_pkg::ST_RUN:
					if (hold_end)
						st_q <= aoc_pkg::ST_IDLE;
					else if (tick)
					begin
						hold_ms_q <= hold_ms_q + HW'(1);
						ms_q      <= phase_end ? '0 : ms_nx;
					end
				aoc_pkg::ST_IDLE:
					ms_q <= '0;
				default:
					st_q <= aoc_pkg::ST_IDLE;
			endcase
		end
	end

	// Level holds after hold time ends; output is the level the retention store saves
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			out_level   <= 1'b0;
			init_pend_q <= 1'b1;
		end
		else if (init_apply)
		begin
			init_pend_q <= 1'b0;
			case (wr_val[6:5])
				aoc_pkg::INIT_LAST: out_level <= saved_level;
				aoc_pkg::INIT_HIGH: out_level <= 1'b1;
				default:            out_level <= 1'b0;
			endcase
		end
		else if (go_run)
		begin
			init_pend_q <= 1'b0;
			case (trig ? act_new : act_q)
				aoc_pkg::ACT_HIGH:  out_level <= 1'b1;
				aoc_pkg::ACT_PULSE: out_level <= 1'b1;
				default:            out_level <= 1'b0;
			endcase
		end
		else if (phase_end)
			out_level <= ~out_level;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_disabled;
		!cfg_q.en |=> st_q == aoc_pkg::ST_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled channel active");

	property p_high;
		st_q == aoc_pkg::ST_RUN && act_q == aoc_pkg::ACT_HIGH |-> out_level;
	endproperty
	a_high: assert property (p_high) else $error("high action not high");

	property p_low;
		st_q == aoc_pkg::ST_RUN && act_q == aoc_pkg::ACT_LOW |-> !out_level;
	endproperty
	a_low: assert property (p_low) else $error("low action not low");

	property p_toggle;
		phase_end |=> out_level != $past(out_level);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pulse phase did not flip");

	property p_last;
		init_apply && wr_val[6:5] == aoc_pkg::INIT_LAST |=> out_level == $past(saved_level);
	endproperty
	a_last: assert property (p_last) else $error("last level not restored");

	property p_delay;
		st_q == aoc_pkg::ST_DELAY |-> ms_q < delay_q && delay_q <= aoc_pkg::DELAY_MAX_MS;
	endproperty
	a_delay: assert property (p_delay) else $error("delay overran");

	property p_hold;
		st_q == aoc_pkg::ST_RUN && hold_q != '0 && !$changed(hold_q) |-> hold_ms_q < hold_lim;
	endproperty
	a_hold: assert property (p_hold) else $error("hold time overran");

	property p_lo_range;
		low_w_q >= aoc_pkg::WIDTH_MIN_MS && low_w_q <= aoc_pkg::WIDTH_MAX_MS;
	endproperty
	a_lo_range: assert property (p_lo_range) else $error("low width out of range");

	property p_hi_range;
		high_w_q >= aoc_pkg::WIDTH_MIN_MS && high_w_q <= aoc_pkg::WIDTH_MAX_MS;
	endproperty
	a_hi_range: assert property (p_hi_range) else $error("high width out of range");

	property p_restart;
		trig |=> st_q != aoc_pkg::ST_IDLE && ms_q == '0 && hold_ms_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("trigger did not restart");

	c_pulse: cover property (phase_end);
	c_delay: cover property (st_q == aoc_pkg::ST_DELAY ##1 st_q == aoc_pkg::ST_RUN);
	c_hold:  cover property (hold_end);

endmodule
`default_nettype wire

// [tb/aoc_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module aoc_load_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic out_level,
	output var  logic saved_level,
	output var  int   hi_len,
	output var  int   lo_len
);
	logic prev;
	logic armed;
	int   run_len;

	initial
	begin
		saved_level = 1'b0;
		prev = 1'b0;
		armed = 1'b0;
		run_len = 0;
		hi_len = 0;
		lo_len = 0;
	end

	// Store stops recording in reset and until the level moves again,
	// otherwise the forced low of reset would wipe the retained level
	always @(posedge clk)
	begin
		prev <= out_level;
		if (!rst_n)
			armed <= 1'b0;
		else if (out_level !== prev)
			armed <= 1'b1;
		if (rst_n && (armed || out_level !== prev))
			saved_level <= out_level;
		if (out_level !== prev)
		begin
			if (prev === 1'b1)
				hi_len <= run_len;
			else
				lo_len <= run_len;
			run_len <= 1;
		end
		else
			run_len <= run_len + 1;
	end
endmodule
`default_nettype wire

// [tb/aoc_output_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module aoc_output_ctrl_tb;
	// Short tick keeps second-long holds and widths affordable
	localparam int TICK = 10;
	logic        clk;
	logic        rst_n;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic [1:0]  wresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [1:0]  pins;
	logic        saved;
	logic        out_level;
	int          hi_len;
	int          lo_len;
	int          num_errors = 0;
	int          samples_checked = 0;

	aoc_output_ctrl #(.TICK_CYCLES(TICK)) dut (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sensed_input_channel(pins),
		.saved_level(saved), .out_level(out_level)
	);

	aoc_load_model load (
		.clk(clk), .rst_n(rst_n), .out_level(out_level), .saved_level(saved), .hi_len(hi_len), .lo_len(lo_len)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] cw(input logic en, input logic [1:0] on, input logic [1:0] off,
		input logic [1:0] ini = aoc_pkg::INIT_LOW, input logic src = 1'b0, input logic [1:0] inv = 2'h0);
		return {22'h0, inv, src, ini, off, on, en};
	endfunction

	task automatic complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic hang;
		num_errors++;
		complete_run();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int exp, input int tol);
		samples_checked++;
		if (got < exp - tol || got > exp + tol)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pin(input logic [1:0] v);
		@(posedge clk);
		pins <= v;
	endtask

	// Done flags, since the loop test would see the strobes before they rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic aw_done;
		logic w_done;
		logic b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; !b_done; n++)
		begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
			if (bvalid === 1'b1)
			begin
				wresp = bresp;
				bready <= 1'b0;
				b_done = 1'b1;
			end
			if (n > 50)
				hang();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic ar_done;
		logic r_done;
		ar_done = 1'b0;
		r_done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; !r_done; n++)
		begin
			@(posedge clk);
			if (!ar_done && arready === 1'b1)
			begin
				arvalid <= 1'b0;
				ar_done = 1'b1;
			end
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				r_done = 1'b1;
			end
			if (n > 50)
				hang();
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
	endtask

	task automatic wl(input logic v, input int n);
		int i;
		for (i = 0; out_level !== v; i++)
		begin
			if (i > n)
				hang();
			@(posedge clk);
		end
		chk(out_level, v);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		chk(out_level, 1'b0);
		rc(aoc_pkg::OFF_CTRL, cw(1'b0, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW));
		rc(aoc_pkg::OFF_DELAY, 32'h0);
		rc(aoc_pkg::OFF_HOLD, 32'h0);
		rc(aoc_pkg::OFF_LOW_W, 32'h3e8);
		rc(aoc_pkg::OFF_HIGH_W, 32'h3e8);
		rd(8'h24, d, r);
		chk(r, aoc_pkg::RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'h24, 32'hffffffff);
		chk(wresp, aoc_pkg::RESP_SLVERR);
	endtask

	task automatic t_disabled;
		wr(aoc_pkg::OFF_CTRL, cw(1'b0, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW, aoc_pkg::INIT_HIGH));
		chk(wresp, aoc_pkg::RESP_OKAY);
		wl(1'b1, 10);
		pin(2'b01);
		pin(2'b00);
		cyc(20);
		chk(out_level, 1'b1);
		rc(aoc_pkg::OFF_CNT1, 32'h1);
	endtask

	task automatic t_levels;
		logic b;
		for (int k = 0; k < 2; k++)
		begin
			b = (k == 0);
			wr(aoc_pkg::OFF_CTRL, cw(1'b1, {1'b0, b}, {1'b0, ~b}));
			pin(2'b01);
			wl(~b, 10);
			pin(2'b00);
			wl(b, 10);
		end
	endtask

	task automatic t_pulse;
		wr(aoc_pkg::OFF_DELAY, 32'h5);
		wr(aoc_pkg::OFF_HIGH_W, 32'h5dc);
		wr(aoc_pkg::OFF_LOW_W, 32'h1f4);
		rc(aoc_pkg::OFF_LOW_W, 32'h3e8);
		wr(aoc_pkg::OFF_CTRL, cw(1'b1, aoc_pkg::ACT_PULSE, aoc_pkg::ACT_LOW));
		pin(2'b01);
		cyc(30);
		chk(out_level, 1'b0);
		wl(1'b1, 40);
		// Model books a run length one edge after the level moves
		wl(1'b0, 1500 * TICK + 100);
		cyc(1);
		chk_rng(hi_len, 1500 * TICK, TICK);
		wl(1'b1, 1000 * TICK + 100);
		cyc(1);
		chk_rng(lo_len, 1000 * TICK, TICK);
		// Release in the high phase must cut the wave short after the delay
		pin(2'b00);
		wl(1'b0, 80);
		wr(aoc_pkg::OFF_DELAY, 32'h0);
	endtask

	task automatic t_hold;
		logic [31:0] d;
		logic [1:0]  r;
		wr(aoc_pkg::OFF_HOLD, 32'h1);
		wr(aoc_pkg::OFF_CTRL, cw(1'b1, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW));
		pin(2'b01);
		wl(1'b1, 10);
		rd(aoc_pkg::OFF_STATUS, d, r);
		chk(d[4:3], aoc_pkg::ST_RUN);
		cyc(1000 * TICK + 100);
		rd(aoc_pkg::OFF_STATUS, d, r);
		chk(d[4:3], aoc_pkg::ST_IDLE);
		chk(out_level, 1'b1);
		wr(aoc_pkg::OFF_HOLD, 32'h0);
		pin(2'b00);
		wl(1'b0, 10);
	endtask

	task automatic t_src_inv;
		wr(aoc_pkg::OFF_CTRL, cw(1'b1, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW, aoc_pkg::INIT_LOW, 1'b1));
		pin(2'b01);
		cyc(20);
		chk(out_level, 1'b0);
		pin(2'b10);
		wl(1'b1, 10);
		pin(2'b00);
		wl(1'b0, 10);
		wr(aoc_pkg::OFF_CTRL, cw(1'b1, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW, aoc_pkg::INIT_LOW, 1'b1, 2'h2));
		wl(1'b1, 10);
		pin(2'b10);
		wl(1'b0, 10);
		pin(2'b00);
		wl(1'b1, 10);
	endtask

	task automatic t_clear;
		wr(aoc_pkg::OFF_CLEAR, 32'h1);
		rc(aoc_pkg::OFF_CNT1, 32'h0);
		rc(aoc_pkg::OFF_CNT2, 32'h3);
		wr(aoc_pkg::OFF_CLEAR, 32'h2);
		rc(aoc_pkg::OFF_CNT2, 32'h0);
	endtask

	task automatic t_last;
		@(posedge clk);
		rst_n <= 1'b0;
		cyc(2);
		chk(out_level, 1'b0);
		rst_n <= 1'b1;
		rc(aoc_pkg::OFF_CTRL, cw(1'b0, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW));
		wr(aoc_pkg::OFF_CTRL, cw(1'b0, aoc_pkg::ACT_HIGH, aoc_pkg::ACT_LOW, aoc_pkg::INIT_LAST));
		wl(1'b1, 10);
	endtask

	initial
	begin
		rst_n = 1'b0;
		awaddr = 8'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h0;
		arvalid = 1'b0;
		rready = 1'b0;
		pins = 2'b00;
		cyc(6);
		rst_n <= 1'b1;
		t_reset();
		t_disabled();
		t_levels();
		t_pulse();
		t_hold();
		t_src_inv();
		t_clear();
		t_last();
		complete_run();
	end
endmodule
`default_nettype wire
